/* File: design/dead_time_pwm_timer.sv */
// dead-time pwm sequencer with per-input fault and trigger actions
`timescale 1ns/10ps
`default_nettype none

module dead_time_pwm_timer
  import pwm_input_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // events from the routing fabric
  input  wire logic              event_a,
  input  wire logic              event_b,
  // per-input action select and restart command
  input  wire logic [MODE_W-1:0] input_action_select_a,
  input  wire logic [MODE_W-1:0] input_action_select_b,
  input  wire logic              restart_cmd,
  // phase lengths, in clocks minus one
  input  wire logic [CNT_W-1:0]  dead_a_len,
  input  wire logic [CNT_W-1:0]  on_a_len,
  input  wire logic [CNT_W-1:0]  dead_b_len,
  input  wire logic [CNT_W-1:0]  on_b_len,
  // waveform outputs
  output wire logic              waveform_out_a,
  output wire logic              waveform_out_b,
  // capture triggers and status
  output wire logic              capture_trig_a,
  output wire logic              capture_trig_b,
  output wire logic [1:0]        phase_o,
  output wire logic              counter_held
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("dead_time_pwm_timer: CNT_W must lie in 2..16");
  end

  phase_t             phase_q;
  phase_t             phase_d;
  phase_t             jump_tgt;
  phase_t             end_tgt;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   cnt_d;
  logic [CNT_W-1:0]   cur_len;
  logic [1:0]         evt_in;
  logic [1:0]         lvl;
  logic [1:0]         rise;
  logic [MODE_W-1:0]  sel [2];
  logic [1:0]         own_side;
  logic [1:0]         own_on;
  logic [1:0]         trig_split;
  logic [1:0]         trig_edge;
  logic [1:0]         trig_share;
  logic [1:0]         lvl4;
  logic [1:0]         lvl5;
  logic [1:0]         lvl6;
  logic [1:0]         lvl7;
  logic [1:0]         lvl3;
  logic [1:0]         lvl10;
  logic [1:0]         blk_set;
  logic [1:0]         stall2;
  logic [1:0]         m1_q;
  logic [1:0]         m1_d;
  logic [1:0]         m2_q;
  logic [1:0]         m2_d;
  logic [1:0]         blk_q;
  logic [1:0]         blk_d;
  logic [1:0]         kill;
  logic [1:0]         wave_q;
  logic [1:0]         wave_d;
  logic               stop_q;
  logic               stop_d;
  logic               wait6_q;
  logic               wait6_d;
  logic               phase_end;
  logic               jump_any;
  logic               freeze6;
  logic               freeze;
  logic               stopped;
  logic               adv;
  logic               kill_all;

  assign evt_in = {event_b, event_a};
  assign sel[0] = input_action_select_a;
  assign sel[1] = input_action_select_b;

  // per-input synchronisers and action decode
  for (genvar i = 0; i < 2; i++) begin : g_in
    event_sync #(
      .STAGES   (SYNC_STAGES)
    ) u_sync (
      .mclk     (mclk),
      .srst     (srst),
      .async_in (evt_in[i]),
      .level    (lvl[i]),
      .rise     (rise[i])
    );

    // exact code compares; codes above ten match nothing
    assign own_side[i]   = on_side(phase_q, 1'(i));
    assign own_on[i]     = (phase_q == on_of(1'(i)));
    assign trig_split[i] = lvl[i] & own_side[i]
                         & ((sel[i] == MODE_STOP_JUMP) | (sel[i] == MODE_RUN_OPP_WAIT)
                         | (sel[i] == MODE_REPEAT_OPP));
    assign trig_edge[i]  = (sel[i] == MODE_EDGE_JUMP) & rise[i] & own_on[i];
    assign trig_share[i] = lvl[i] & ~is_dead(phase_q)
                         & ((sel[i] == MODE_DEAD_ONLY) | (sel[i] == MODE_JUMP_WAIT_ALL));
    assign lvl3[i]       = lvl[i] & (sel[i] == MODE_REPEAT_OPP);
    assign lvl4[i]       = lvl[i] & (sel[i] == MODE_STOP_ALL);
    assign lvl5[i]       = lvl[i] & (sel[i] == MODE_DEAD_ONLY);
    assign lvl6[i]       = lvl[i] & (sel[i] == MODE_JUMP_WAIT_ALL);
    assign lvl7[i]       = lvl[i] & (sel[i] == MODE_SW_RESTART);
    assign lvl10[i]      = lvl[i] & (sel[i] == MODE_LEVEL_BLOCK);
    assign blk_set[i]    = own_on[i] & ((rise[i] & (sel[i] == MODE_EDGE_BLOCK)) | lvl10[i]);
    assign stall2[i]     = m2_q[i] & lvl[i] & phase_end & (phase_q == on_of(~1'(i)));

    // wait flags: code 1 holds while high, code 2 waits at end of opposite on-time
    assign m1_d[i]  = (trig_split[i] & (sel[i] == MODE_STOP_JUMP)) | (m1_q[i] & lvl[i]);
    assign m2_d[i]  = (trig_split[i] & (sel[i] == MODE_RUN_OPP_WAIT))
                    | (m2_q[i] & ~(adv & (phase_q == on_of(~1'(i)))));
    assign blk_d[i] = blk_set[i] | (blk_q[i] & own_on[i] & (phase_d == phase_q) & ~restart_cmd);

    // per-output kill: shared codes hit both, split codes their own
    assign kill[i]   = kill_all | blk_set[i] | blk_q[i] | lvl10[i] | trig_split[i] | trig_edge[i];
    assign wave_d[i] = own_on[i] & ~kill[i];
  end

  // shared-code conditions covering both outputs
  assign kill_all = stopped | (|lvl4) | (|lvl5) | (|lvl6);
  assign stopped  = stop_q | (|lvl7);
  assign stop_d   = (|lvl7) | (stop_q & ~restart_cmd);

  // phase length and end of phase
  assign cur_len   = (phase_q == PH_DEAD_A) ? dead_a_len :
                     (phase_q == PH_ON_A)   ? on_a_len   :
                     (phase_q == PH_DEAD_B) ? dead_b_len : on_b_len;
  assign phase_end = (cnt_q == cur_len);

  // jump requests: input A first, then B, then shared codes
  assign jump_any = (|trig_split) | (|trig_edge) | (|trig_share);
  assign jump_tgt = (trig_split[0] | trig_edge[0]) ? PH_DEAD_B :
                    (trig_split[1] | trig_edge[1]) ? PH_DEAD_A :
                    dead_of(~on_side(phase_q, SIDE_B));

  // holds: code 1 while high, code 2 stall, code 6 at end of dead-time
  assign freeze6 = (|lvl6) & is_dead(phase_q) & phase_end;
  assign freeze  = (|(m1_q & lvl)) | (|stall2) | freeze6;

  // phase after a normal end, with code 3, 5 and 6 redirections
  assign end_tgt = wait6_q                                ? dead_of(~on_side(phase_q, SIDE_B)) :
                   ((phase_q == PH_ON_B) & lvl3[SIDE_A])  ? PH_DEAD_B :
                   ((phase_q == PH_ON_A) & lvl3[SIDE_B])  ? PH_DEAD_A :
                   (is_dead(phase_q) & (|lvl5))           ? dead_of(~on_side(phase_q, SIDE_B)) :
                   seq_next(phase_q);

  assign adv = ~restart_cmd & ~stopped & ~jump_any & ~freeze & phase_end;
  assign wait6_d = freeze6 | (wait6_q & ~adv);

  // sequencer next state
  always_comb
  begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    if (restart_cmd)
    begin
      phase_d = PH_DEAD_A;
      cnt_d   = '0;
    end
    else if (stopped)
    begin
      phase_d = phase_q;
      cnt_d   = cnt_q;
    end
    else if (jump_any)
    begin
      phase_d = jump_tgt;
      cnt_d   = '0;
    end
    else if (freeze)
    begin
      phase_d = phase_q;
      cnt_d   = cnt_q;
    end
    else if (phase_end)
    begin
      phase_d = end_tgt;
      cnt_d   = '0;
    end
    else
    begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
    end
  end

  // state registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      phase_q <= PH_DEAD_A;
      cnt_q   <= '0;
      stop_q  <= 1'b0;
      wait6_q <= 1'b0;
      m1_q    <= '0;
      m2_q    <= '0;
      blk_q   <= '0;
      wave_q  <= '0;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      stop_q  <= stop_d;
      wait6_q <= wait6_d;
      m1_q    <= m1_d;
      m2_q    <= m2_d;
      blk_q   <= blk_d;
      wave_q  <= wave_d;
    end
  end

  // outputs
  assign waveform_out_a = wave_q[0];
  assign waveform_out_b = wave_q[1];
  assign capture_trig_a = rise[0];
  assign capture_trig_b = rise[1];
  assign phase_o        = phase_q;
  assign counter_held   = stopped | freeze;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence edge_block_s;
    blk_set[0] ##1 1'b1;
  endsequence

  sequence fault4_held_s;
    (sel[0] == MODE_STOP_ALL && event_a) [*3];
  endsequence

  stop_all_a: assert property (|lvl4 |=> !waveform_out_a && !waveform_out_b)
    else $error("outputs on during stop-all fault");

  mode4_count_a: assert property ((sel[0] == MODE_STOP_ALL && sel[1] == MODE_STOP_ALL && !restart_cmd
      && !phase_end) |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
    else $error("counter disturbed in stop-all mode");

  wait_hold_a: assert property ((m1_q[0] && lvl[0] && !restart_cmd && !stopped) |=> $stable(cnt_q))
    else $error("counter moved during code 1 wait");

  jump_opp_a: assert property ((trig_split[0] && sel[0] == MODE_STOP_JUMP && !restart_cmd && !stopped)
      |=> phase_q == PH_DEAD_B && cnt_q == '0)
    else $error("code 1 on A did not jump to dead-time B");

  sw_stop_a: assert property ((stop_q && !restart_cmd) |=> $stable(phase_q) && $stable(cnt_q))
    else $error("sequence moved while stopped");

  restart_dta_a: assert property (restart_cmd |=> phase_q == PH_DEAD_A && cnt_q == '0)
    else $error("restart did not begin at dead-time A");

  edge_jump_a: assert property ((trig_edge[1] && !trig_split[0] && !trig_edge[0] && !restart_cmd
      && !stopped) |=> phase_q == PH_DEAD_A)
    else $error("code 8 on B did not jump to dead-time A");

  edge_block_a: assert property (edge_block_s |-> !waveform_out_a)
    else $error("output A on after code 9 edge");

  fault_latency_a: assert property (fault4_held_s |=> !waveform_out_a)
    else $error("override later than three clocks");

  dead_alt_a: assert property ((|lvl5 && is_dead(phase_q) && phase_end && !restart_cmd && !stopped
      && !jump_any && !freeze) |=> is_dead(phase_q) && phase_q != $past(phase_q))
    else $error("dead-times did not alternate");

  level_block_a: assert property (lvl10[1] |=> !waveform_out_b)
    else $error("output B on during code 10 fault");

endmodule : dead_time_pwm_timer
`default_nettype wire

/* File: design/pwm_input_pkg.sv */
// shared constants, phase type and phase helpers for the dead-time pwm timer
package pwm_input_pkg;

  // width of the per-input action select field
  localparam int MODE_W = 4;

  // input action codes
  localparam logic [MODE_W-1:0] MODE_NONE          = 4'h0;
  localparam logic [MODE_W-1:0] MODE_STOP_JUMP     = 4'h1;
  localparam logic [MODE_W-1:0] MODE_RUN_OPP_WAIT  = 4'h2;
  localparam logic [MODE_W-1:0] MODE_REPEAT_OPP    = 4'h3;
  localparam logic [MODE_W-1:0] MODE_STOP_ALL      = 4'h4;
  localparam logic [MODE_W-1:0] MODE_DEAD_ONLY     = 4'h5;
  localparam logic [MODE_W-1:0] MODE_JUMP_WAIT_ALL = 4'h6;
  localparam logic [MODE_W-1:0] MODE_SW_RESTART    = 4'h7;
  localparam logic [MODE_W-1:0] MODE_EDGE_JUMP     = 4'h8;
  localparam logic [MODE_W-1:0] MODE_EDGE_BLOCK    = 4'h9;
  localparam logic [MODE_W-1:0] MODE_LEVEL_BLOCK   = 4'hA;

  // synchroniser depth and resulting event-to-output latency in clocks
  localparam int SYNC_STAGES       = 2;
  localparam int OVERRIDE_LATENCY  = SYNC_STAGES + 1;

  // input sides
  localparam logic SIDE_A = 1'b0;
  localparam logic SIDE_B = 1'b1;

  // the four phases of one timer cycle
  typedef enum logic [1:0] {PH_DEAD_A, PH_ON_A, PH_DEAD_B, PH_ON_B} phase_t;

  // phase is a dead-time
  function automatic logic is_dead(phase_t p);
    return (p == PH_DEAD_A) || (p == PH_DEAD_B);
  endfunction : is_dead

  // phase belongs to the given side
  function automatic logic on_side(phase_t p, logic side);
    return side ? ((p == PH_DEAD_B) || (p == PH_ON_B)) : ((p == PH_DEAD_A) || (p == PH_ON_A));
  endfunction : on_side

  // on-time of a side
  function automatic phase_t on_of(logic side);
    return side ? PH_ON_B : PH_ON_A;
  endfunction : on_of

  // dead-time of a side
  function automatic phase_t dead_of(logic side);
    return side ? PH_DEAD_B : PH_DEAD_A;
  endfunction : dead_of

  // normal phase order
  function automatic phase_t seq_next(phase_t p);
    phase_t n;
    n = PH_DEAD_A;
    unique case (p)
      PH_DEAD_A: n = PH_ON_A;
      PH_ON_A:   n = PH_DEAD_B;
      PH_DEAD_B: n = PH_ON_B;
      PH_ON_B:   n = PH_DEAD_A;
    endcase
    return n;
  endfunction : seq_next

endpackage : pwm_input_pkg

/* File: design/event_sync.sv */
// two-flop event synchroniser with rising-edge pulse
`timescale 1ns/10ps
`default_nettype none

module event_sync
#(
  parameter int STAGES = 2
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // raw event
  input  wire logic async_in,
  // synchronised level and edge
  output wire logic level,
  output wire logic rise
);

  if (STAGES < 2) begin : g_bad_stages
    $error("event_sync needs at least two stages");
  end

  logic [STAGES-1:0] sync_q;
  logic              prev_q;

  // shift chain; stage 0 feeds only stage 1
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sync_q <= '0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[STAGES-2:0], async_in};
      prev_q <= sync_q[STAGES-1];
    end
  end

  // outputs from the last stage only
  assign level = sync_q[STAGES-1];
  assign rise  = sync_q[STAGES-1] & ~prev_q;

endmodule : event_sync
`default_nettype wire

/* File: tb/event_fabric.sv */
// event routing fabric model feeding the timer inputs
`timescale 1ns/10ps
`default_nettype none

module event_fabric
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // levels asked for by the bench
  input  wire logic req_a,
  input  wire logic req_b,
  // events toward the timer
  output var  logic event_a,
  output var  logic event_b
);
  // one flop of channel delay, cleared by reset
  always_ff @(posedge mclk)
  begin
    {event_a, event_b} <= srst ? 2'h0 : {req_a, req_b};
  end
endmodule : event_fabric

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the timer input actions
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import pwm_input_pkg::*;

  typedef struct {int k; logic [1:0] v;} note_t;

  logic              mclk;
  logic              srst;
  logic              req_a;
  logic              req_b;
  logic              restart_cmd;
  logic [MODE_W-1:0] sel_a;
  logic [MODE_W-1:0] sel_b;
  logic [3:0]        len [4];
  wire               event_a;
  wire               event_b;
  wire               out_a;
  wire               out_b;
  wire               cap_a;
  wire               cap_b;
  wire               held;
  wire  [1:0]        phase;
  int                err_count;
  int                compares;
  int                cap_n;
  int                cap_bn;
  int                tick;
  note_t             notes [$];
  note_t             n;
  string             names [7] = '{"phase", "out_a", "out_b", "held", "outs", "captures", "captures_b"};

  // far side and the timer
  event_fabric fab (.mclk(mclk), .srst(srst), .req_a(req_a), .req_b(req_b), .event_a(event_a), .event_b(event_b));

  dead_time_pwm_timer #(.CNT_W(4)) dut
  (
    .mclk(mclk), .srst(srst), .event_a(event_a), .event_b(event_b),
    .input_action_select_a(sel_a), .input_action_select_b(sel_b), .restart_cmd(restart_cmd),
    .dead_a_len(len[0]), .on_a_len(len[1]), .dead_b_len(len[2]), .on_b_len(len[3]),
    .waveform_out_a(out_a), .waveform_out_b(out_b), .capture_trig_a(cap_a),
    .capture_trig_b(cap_b), .phase_o(phase), .counter_held(held)
  );

  // value of the output class named by a note
  function automatic logic [1:0] seen(int k);
    case (k)
      0: return phase;
      1: return {1'b0, out_a};
      2: return {1'b0, out_b};
      3: return {1'b0, held};
      4: return {out_a, out_b};
      5: return cap_n[1:0];
      default: return cap_bn[1:0];
    endcase
  endfunction : seen

  task automatic chk(string what, logic [1:0] got, logic [1:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic nt(int k, logic [1:0] v);
    notes.push_back('{k, v});
  endtask : nt

  task automatic cyc(int c);
    repeat (c) @(posedge mclk);
  endtask : cyc

  // wait for a phase, sampled where it is settled
  task automatic wp(logic [1:0] p);
    int i;
    @(negedge mclk);
    for (i = 0; i < 60 && phase !== p; i++)
      @(negedge mclk);
    if (i == 60)
      nt(0, p);
    @(posedge mclk);
  endtask : wp

  // wait for the next phase change and note which phase it must be
  task automatic np(logic [1:0] p);
    logic [1:0] cur;
    int i;
    @(negedge mclk);
    cur = phase;
    for (i = 0; i < 60 && phase === cur; i++)
      @(negedge mclk);
    nt(0, p);
    @(posedge mclk);
  endtask : np

  // fresh reset with a code per input
  task automatic start(logic [3:0] ma, logic [3:0] mb);
    srst <= 1'b1;
    req_a <= 1'b0;
    req_b <= 1'b0;
    sel_a <= ma;
    sel_b <= mb;
    cyc(2);
    srst <= 1'b0;
    cap_n = 0;
    cap_bn = 0;
    cyc(1);
  endtask : start

  task automatic rs();
    restart_cmd <= 1'b1;
    cyc(1);
    restart_cmd <= 1'b0;
    cyc(1);
  endtask : rs

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk)
  begin
    tick++;
    if (tick == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // takes notes in order and compares them to the outputs
  always @(negedge mclk)
  begin
    if (cap_a === 1'b1)
      cap_n++;
    if (cap_b === 1'b1)
      cap_bn++;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      chk(names[n.k], seen(n.k), n.v);
      if (n.k == 5)
        cap_n = 0;
      if (n.k == 6)
        cap_bn = 0;
    end
  end

  initial
  begin
    srst = 1'b1;
    {req_a, req_b, restart_cmd} = 3'h0;
    sel_a = MODE_NONE;
    sel_b = MODE_NONE;
    void'($urandom(32'h8741));
    foreach (len[i])
      len[i] = 4'($urandom_range(3, 2) + 4 * (i % 2));
    cyc(5);
    // no action on A, undefined code on B
    start(MODE_NONE, 4'($urandom_range(15, 11)));
    wp(PH_ON_A);
    {req_a, req_b} <= 2'h3;
    cyc(5);
    nt(1, 2'h1);
    np(PH_DEAD_B);
    np(PH_ON_B);
    nt(2, 2'h1);
    nt(5, 2'h1);
    nt(6, 2'h1);
    // both outputs off, counter free
    start(MODE_STOP_ALL, MODE_STOP_ALL);
    wp(PH_ON_A);
    req_b <= 1'b1;
    cyc(5);
    nt(4, 2'h0);
    np(PH_DEAD_B);
    np(PH_ON_B);
    nt(4, 2'h0);
    // A ignored in B phases, then jump and wait
    start(MODE_STOP_JUMP, MODE_NONE);
    wp(PH_DEAD_B);
    req_a <= 1'b1;
    wp(PH_ON_B);
    req_a <= 1'b0;
    cyc(2);
    nt(2, 2'h1);
    wp(PH_ON_A);
    req_a <= 1'b1;
    cyc(14);
    nt(0, PH_DEAD_B);
    nt(3, 2'h1);
    req_a <= 1'b0;
    np(PH_ON_B);
    // run opposite phases, then wait
    start(MODE_RUN_OPP_WAIT, MODE_NONE);
    wp(PH_ON_A);
    req_a <= 1'b1;
    np(PH_DEAD_B);
    np(PH_ON_B);
    cyc(12);
    nt(3, 2'h1);
    req_a <= 1'b0;
    np(PH_DEAD_A);
    // early release: opposite phases run out, no wait
    start(MODE_RUN_OPP_WAIT, MODE_NONE);
    wp(PH_ON_A);
    req_a <= 1'b1;
    np(PH_DEAD_B);
    req_a <= 1'b0;
    np(PH_ON_B);
    np(PH_DEAD_A);
    // opposite phases repeat while active
    start(MODE_REPEAT_OPP, MODE_NONE);
    wp(PH_ON_A);
    req_a <= 1'b1;
    np(PH_DEAD_B);
    np(PH_ON_B);
    np(PH_DEAD_B);
    req_a <= 1'b0;
    np(PH_ON_B);
    np(PH_DEAD_A);
    // dead-times only while active
    start(MODE_DEAD_ONLY, MODE_NONE);
    wp(PH_ON_A);
    req_a <= 1'b1;
    cyc(5);
    nt(0, PH_DEAD_B);
    repeat (4)
    begin
      cyc(5);
      nt(4, 2'h0);
      nt(3, 2'h0);
    end
    // jump and hold, driven from B
    start(MODE_NONE, MODE_JUMP_WAIT_ALL);
    wp(PH_ON_A);
    req_b <= 1'b1;
    cyc(14);
    nt(0, PH_DEAD_B);
    nt(3, 2'h1);
    req_b <= 1'b0;
    np(PH_DEAD_A);
    // stop until restart, restart from dead A
    start(MODE_SW_RESTART, MODE_SW_RESTART);
    wp(PH_ON_B);
    req_b <= 1'b1;
    cyc(2);
    req_b <= 1'b0;
    cyc(20);
    nt(0, PH_ON_B);
    nt(4, 2'h0);
    rs();
    nt(0, PH_DEAD_A);
    nt(3, 2'h0);
    req_a <= 1'b1;
    cyc(6);
    rs();
    cyc(1);
    nt(3, 2'h1);
    // edge jump on B
    start(MODE_NONE, MODE_EDGE_JUMP);
    wp(PH_ON_B);
    req_b <= 1'b1;
    cyc(5);
    nt(0, PH_DEAD_A);
    // edge blanks the rest of one on-time
    start(MODE_EDGE_BLOCK, MODE_NONE);
    wp(PH_ON_A);
    req_a <= 1'b1;
    cyc(5);
    nt(1, 2'h0);
    np(PH_DEAD_B);
    wp(PH_ON_A);
    cyc(2);
    nt(1, 2'h1);
    // level blank, kept to end of on-time
    start(MODE_LEVEL_BLOCK, MODE_NONE);
    wp(PH_DEAD_B);
    req_a <= 1'b1;
    wp(PH_ON_A);
    req_a <= 1'b0;
    cyc(5);
    nt(1, 2'h0);
    np(PH_DEAD_B);
    wp(PH_ON_A);
    cyc(2);
    nt(1, 2'h1);
    cyc(4);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
